// *** src/smh_fault_filter.sv ***
module smh_fault_filter import smh_pkg::*; (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input smh_cyc_t i_cyc,
   output logic o_set,
   output logic [5:0] o_dev,
   output logic [3:0] o_code
);
   // ----------------------------------------
   // repeat counter per device
   // ----------------------------------------
   logic [3:0] last_r [NUM_DEV];
   logic [1:0] cnt_r [NUM_DEV];
   logic [1:0] cnt_nxt;

   always_comb begin
      cnt_nxt = 2'd1;
      if (i_cyc.fault == 4'h0) begin
         cnt_nxt = 2'd0;
      end else if (i_cyc.fault == last_r[i_cyc.dev] && cnt_r[i_cyc.dev] != 2'd3) begin
         cnt_nxt = cnt_r[i_cyc.dev] + 2'd1;
      end else if (i_cyc.fault == last_r[i_cyc.dev]) begin
         cnt_nxt = 2'd3;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < NUM_DEV; i++) begin
            last_r[i] <= 4'h0;
            cnt_r[i] <= 2'd0;
         end
      end else if (i_cyc.valid) begin
         last_r[i_cyc.dev] <= i_cyc.fault;
         cnt_r[i_cyc.dev] <= cnt_nxt;
      end
   end

   // flag once, on the third identical report in a row
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_set <= 1'b0;
         o_dev <= 6'h00;
         o_code <= 4'h0;
      end else begin
         o_set <= i_cyc.valid && cnt_nxt == 2'(FAULT_REPEAT) && cnt_r[i_cyc.dev] != 2'd3; // see RL11
         o_dev <= i_cyc.dev;
         o_code <= i_cyc.fault;
      end
   end

   fault_three_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RL11
      o_set |-> $past(cnt_r[i_cyc.dev], 1) == 2'd2 && $past(last_r[i_cyc.dev], 1) == o_code)
      else $error("fault flagged without two earlier identical reports");
endmodule : smh_fault_filter

// *** src/smh_fifo.sv ***
module smh_fifo import smh_pkg::*; (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_push,
   input wire logic [15:0] i_data,
   input wire logic i_pop,
   output logic [15:0] o_head,
   output logic o_full,
   output logic o_empty,
   output logic [7:0] o_count
);
   // ----------------------------------------
   // 128 words of 16 bits, 256 bytes
   // ----------------------------------------
   logic [15:0] mem_r [FIFO_WORDS];
   logic [6:0] wp_r;
   logic [6:0] rp_r;
   logic [7:0] cnt_r;
   logic do_push;
   logic do_pop;

   assign do_push = i_push && !o_full;
   assign do_pop = i_pop && !o_empty;
   assign o_full = (cnt_r == 8'(FIFO_WORDS)); // see RL15
   assign o_empty = (cnt_r == 8'h00);
   assign o_count = cnt_r;
   assign o_head = mem_r[rp_r];

   always_ff @(posedge i_clock) begin
      if (do_push) begin
         mem_r[wp_r] <= i_data;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wp_r <= 7'h00;
         rp_r <= 7'h00;
         cnt_r <= 8'h00;
      end else begin
         wp_r <= wp_r + 7'(do_push);
         rp_r <= rp_r + 7'(do_pop);
         cnt_r <= cnt_r + 8'(do_push) - 8'(do_pop);
      end
   end

   fifo_cap_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RL15
      o_full && !i_pop |=> o_full && cnt_r == 8'h80)
      else $error("fifo left full state without a pop");
endmodule : smh_fifo

// *** src/smh_host_map.sv ***
// Notes on behaviour
// RL1: pulse device ports fixed, only port3 output
// RL2: pulse device entry holds its fixed type
// RL3: full mode exposes whole 512-byte map
// RL4: reduced mode: 8-byte window, rest indirect
// RL5: host keeps address bit0 and unused zero
// RL6: host keeps low two bits zero
// RL7: monitored input port change raises interrupt
// RL8: monitor word shared; host read-modify-writes
// RL9: each status read covers four devices
// RL10: status groups advance two bytes each
// RL11: error after three identical faults running
// RL12: status read clears data comm flag
// RL13: data comm flag updates with end flag
// RL14: map is laid out as 16-bit words
// RL15: data fifo holds 256 bytes
// RL16: interrupt low while unmasked flag pending
//
// Our own choices: register access over AHB-Lite and the address map.
module smh_host_map import smh_pkg::*; (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic i_hready,
   input wire logic [31:0] i_hwdata,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   input smh_cyc_t i_cyc,
   input wire logic i_comm_end,
   input wire logic i_comm_err,
   output logic [15:0] o_tx_data,
   output logic o_tx_valid,
   input wire logic i_tx_ready,
   input wire logic [15:0] i_rx_data,
   input wire logic i_rx_valid,
   output logic o_rx_ready,
   output logic o_int_n
);
   // ----------------------------------------
   // storage
   // ----------------------------------------
   logic [7:0] dtype_r [NUM_DEV];
   logic [3:0] dir_r [NUM_DEV];
   logic [3:0] mon_r [NUM_DEV];
   logic [3:0] chg_r [NUM_DEV];
   logic [3:0] err_r [NUM_DEV];
   logic [15:0] cmd_r;
   logic [15:0] data_r;
   logic comm_end_flag_r;
   logic data_comm_status_flag_r;
   logic [2:0] irq_stat_r;
   logic [2:0] irq_mask_r;
   logic full_map_r;
   logic ph_wr_r;
   logic ph_rd_r;
   logic [9:0] ph_addr_r;

   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   logic ap;
   logic [7:0] idx;
   logic map_ok;
   logic ind_go;
   logic ind_wr;
   logic m_wr;
   logic m_rd;
   logic [7:0] m_widx;
   logic [7:0] m_ridx;
   logic [15:0] m_wdata;
   logic [15:0] rd_val;
   logic [15:0] fifo_head;
   logic fifo_full;
   logic fifo_empty;
   logic [7:0] fifo_cnt;
   logic host_push;
   logic host_pop;
   logic err_set;
   logic [5:0] err_dev;
   logic [3:0] err_code;
   logic [3:0] chg_set;
   logic stat_rd;

   assign ap = i_hsel && i_htrans[1] && i_hready;
   assign idx = ph_addr_r[7:0];
   // whole map in full mode, window only in reduced mode
   assign map_ok = ph_addr_r[9:8] == 2'b00 && (full_map_r || idx < IDX_WIN_END); // see RL3 RL4
   assign ind_go = ph_wr_r && map_ok && idx == IDX_CMD; // see RL4
   assign ind_wr = i_hwdata[CMD_WR_BIT];
   // bit0 of the indirect address is dropped, host keeps it zero
   assign m_wr = (ph_wr_r && map_ok && idx != IDX_CMD) || (ind_go && ind_wr); // see RL5
   assign m_widx = ind_go ? i_hwdata[8:1] : idx;
   assign m_wdata = ind_go ? data_r : i_hwdata[15:0];
   assign m_rd = (ph_rd_r && map_ok) || (ind_go && !ind_wr);
   assign m_ridx = ind_go ? i_hwdata[8:1] : idx;
   assign o_hreadyout = !ph_rd_r;
   assign o_hresp = 1'b0;
   assign stat_rd = m_rd && m_ridx == IDX_STAT;

   // reads take one wait state so read data leave a flip-flop
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ph_wr_r <= 1'b0;
         ph_rd_r <= 1'b0;
         ph_addr_r <= 10'h000;
      end else begin
         ph_wr_r <= ap && i_hwrite;
         ph_rd_r <= ap && !i_hwrite;
         if (ap) begin
            ph_addr_r <= i_haddr[11:2];
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_hrdata <= 32'h0000_0000;
      end else if (ph_rd_r) begin
         o_hrdata <= 32'h0000_0000;
         if (map_ok) begin
            o_hrdata <= {16'h0000, rd_val};
         end else if (ph_addr_r == CSR_IRQ_STAT) begin
            o_hrdata <= {29'h0, irq_stat_r};
         end else if (ph_addr_r == CSR_IRQ_MASK) begin
            o_hrdata <= {29'h0, irq_mask_r};
         end else if (ph_addr_r == CSR_CFG) begin
            o_hrdata <= {31'h0, full_map_r};
         end
      end
   end

   // ----------------------------------------
   // map read mux
   // ----------------------------------------
   function automatic logic [3:0] dir_eff(input logic [7:0] dtype, input logic [3:0] dir);
      // pulse devices ignore the stored directions
      return (dtype == PULSE_DEV_TYPE) ? PULSE_DEV_DIR : dir; // see RL1 RL2
   endfunction : dir_eff

   always_comb begin
      logic [5:0] b4;
      logic [5:0] b2;
      b4 = {m_ridx[3:0], 2'b00};
      b2 = {m_ridx[4:0], 1'b0};
      rd_val = 16'h0000;
      unique case (smh_region(m_ridx))
         RG_WIN: begin
            unique case (m_ridx[1:0])
               2'd0: rd_val = cmd_r;
               2'd1: rd_val = data_r;
               2'd2: rd_val = fifo_head;
               2'd3: rd_val = {fifo_cnt, 4'h0, fifo_full, fifo_empty,
                               comm_end_flag_r, data_comm_status_flag_r};
            endcase
         end
         RG_DTYPE: rd_val = {dtype_r[b2 + 6'd1], dtype_r[b2]};
         RG_DIR: begin
            for (int k = 0; k < 4; k++) begin
               rd_val[4*k +: 4] = dir_eff(dtype_r[b4 + 6'(k)], dir_r[b4 + 6'(k)]);
            end
         end
         RG_MON: begin
            for (int k = 0; k < 4; k++) begin
               rd_val[4*k +: 4] = mon_r[b4 + 6'(k)];
            end
         end
         RG_CHG: begin
            // four devices per word, next group two bytes on
            for (int k = 0; k < 4; k++) begin
               rd_val[4*k +: 4] = chg_r[b4 + 6'(k)]; // see RL9 RL10 RL14
            end
         end
         RG_ERR: begin
            for (int k = 0; k < 4; k++) begin
               rd_val[4*k +: 4] = err_r[b4 + 6'(k)]; // see RL9 RL10
            end
         end
         RG_NONE: rd_val = 16'h0000;
      endcase
   end

   // ----------------------------------------
   // window registers
   // ----------------------------------------
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cmd_r <= 16'h0000;
         data_r <= 16'h0000;
      end else begin
         if (ind_go) begin
            cmd_r <= i_hwdata[15:0];
         end
         if (ind_go && !ind_wr) begin
            data_r <= rd_val;
         end else if (m_wr && m_widx == IDX_DATA) begin
            data_r <= m_wdata;
         end
      end
   end

   // ----------------------------------------
   // device tables
   // ----------------------------------------
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < NUM_DEV; i++) begin
            dtype_r[i] <= 8'h00;
            dir_r[i] <= 4'h0;
            mon_r[i] <= 4'h0;
         end
      end else if (m_wr) begin
         for (int k = 0; k < 4; k++) begin
            if (smh_region(m_widx) == RG_DIR) begin
               dir_r[{m_widx[3:0], 2'(k)}] <= m_wdata[4*k +: 4];
            end
            // whole word rewritten, so the host merges neighbours first
            if (smh_region(m_widx) == RG_MON) begin
               mon_r[{m_widx[3:0], 2'(k)}] <= m_wdata[4*k +: 4]; // see RL8
            end
         end
         if (smh_region(m_widx) == RG_DTYPE) begin
            dtype_r[{m_widx[4:0], 1'b0}] <= m_wdata[7:0];
            dtype_r[{m_widx[4:0], 1'b1}] <= m_wdata[15:8];
         end
      end
   end

   // ----------------------------------------
   // change and error flags
   // ----------------------------------------
   assign chg_set = i_cyc.valid ? (i_cyc.chg & mon_r[i_cyc.dev] &
                    ~dir_eff(dtype_r[i_cyc.dev], dir_r[i_cyc.dev])) : 4'h0; // see RL7 RL1

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < NUM_DEV; i++) begin
            chg_r[i] <= 4'h0;
            err_r[i] <= 4'h0;
         end
      end else begin
         // write one clears; a new event in the same cycle wins
         for (int i = 0; i < NUM_DEV; i++) begin
            logic [3:0] c_nxt;
            logic [3:0] e_nxt;
            c_nxt = chg_r[i];
            e_nxt = err_r[i];
            if (m_wr && smh_region(m_widx) == RG_CHG && m_widx[3:0] == 4'(i / 4)) begin
               c_nxt = c_nxt & ~m_wdata[4*(i%4) +: 4];
            end
            if (m_wr && smh_region(m_widx) == RG_ERR && m_widx[3:0] == 4'(i / 4) &&
                m_wdata[4*(i%4) +: 4] != 4'h0) begin
               e_nxt = 4'h0;
            end
            if (i_cyc.dev == 6'(i)) begin
               c_nxt = c_nxt | chg_set; // see RL7
            end
            if (err_set && err_dev == 6'(i)) begin
               e_nxt = err_code; // see RL11
            end
            chg_r[i] <= c_nxt;
            err_r[i] <= e_nxt;
         end
      end
   end

   smh_fault_filter u_filter (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_cyc(i_cyc),
      .o_set(err_set),
      .o_dev(err_dev),
      .o_code(err_code)
   );

   // ----------------------------------------
   // data communication flags
   // ----------------------------------------
   // both flags move on the same edge; end event beats a read
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         comm_end_flag_r <= 1'b0;
         data_comm_status_flag_r <= 1'b0;
      end else if (i_comm_end) begin
         comm_end_flag_r <= 1'b1; // see RL13
         data_comm_status_flag_r <= i_comm_err; // see RL13
      end else if (stat_rd) begin
         comm_end_flag_r <= 1'b0;
         data_comm_status_flag_r <= 1'b0; // see RL12
      end
   end

   // ----------------------------------------
   // data fifo
   // ----------------------------------------
   assign host_push = m_wr && m_widx == IDX_FIFO;
   assign host_pop = m_rd && m_ridx == IDX_FIFO;
   // host access has priority over the link side
   assign o_rx_ready = !fifo_full && !host_push;
   assign o_tx_valid = !fifo_empty && !host_pop;
   assign o_tx_data = fifo_head;

   smh_fifo u_fifo (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_push(host_push || (i_rx_valid && o_rx_ready)),
      .i_data(host_push ? m_wdata : i_rx_data),
      .i_pop(host_pop || (o_tx_valid && i_tx_ready)),
      .o_head(fifo_head),
      .o_full(fifo_full),
      .o_empty(fifo_empty),
      .o_count(fifo_cnt)
   );

   // ----------------------------------------
   // interrupt
   // ----------------------------------------
   logic [2:0] irq_ev;
   logic csr_wr;

   assign irq_ev = {i_comm_end, err_set, chg_set != 4'h0};
   assign csr_wr = ph_wr_r && ph_addr_r[9:8] != 2'b00;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_stat_r <= 3'h0;
      end else if (csr_wr && ph_addr_r == CSR_IRQ_STAT) begin
         irq_stat_r <= (irq_stat_r & ~i_hwdata[2:0]) | irq_ev;
      end else begin
         irq_stat_r <= irq_stat_r | irq_ev;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_mask_r <= IRQ_MASK_RST;
         full_map_r <= CFG_FULL_RST;
      end else if (csr_wr && ph_addr_r == CSR_IRQ_MASK) begin
         irq_mask_r <= i_hwdata[2:0];
      end else if (csr_wr && ph_addr_r == CSR_CFG) begin
         full_map_r <= i_hwdata[0];
      end
   end

   assign o_int_n = !((irq_stat_r & irq_mask_r) != 3'h0); // see RL16

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_rd_wait;
      !o_hreadyout ##1 o_hreadyout;
   endsequence

   rd_wait_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      ap && !i_hwrite |=> s_rd_wait)
      else $error("read did not answer after one wait state");
   flag_sync_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RL13
      i_comm_end |=> comm_end_flag_r && data_comm_status_flag_r == $past(i_comm_err))
      else $error("data flag and end flag out of step");
   stat_clear_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RL12
      stat_rd && !i_comm_end |=> !data_comm_status_flag_r && !comm_end_flag_r)
      else $error("status read left data flag set");
   win_block_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RL4
      ph_wr_r && !full_map_r && ph_addr_r[9:0] >= 10'(IDX_WIN_END) |-> !(m_wr && !ind_go))
      else $error("reduced mode allowed a direct write outside window");
   chg_int_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RL7
      chg_set != 4'h0 && irq_mask_r[IRQ_CHG_BIT] ##1 irq_mask_r[IRQ_CHG_BIT] |-> !o_int_n)
      else $error("monitored change gave no interrupt");
   pulse_dir_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RL1
      i_cyc.valid && dtype_r[i_cyc.dev] == PULSE_DEV_TYPE |-> !chg_set[3])
      else $error("output port of pulse device raised a change");
   int_clear_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see RL16
      irq_stat_r == 3'h0 && irq_ev == 3'h0 |=> o_int_n)
      else $error("interrupt asserted with nothing pending");
endmodule : smh_host_map

// *** src/smh_pkg.sv ***
package smh_pkg;
   // ----------------------------------------
   // map layout, 16-bit word index
   // ----------------------------------------
   localparam logic [7:0] IDX_CMD = 8'h00;
   localparam logic [7:0] IDX_DATA = 8'h01;
   localparam logic [7:0] IDX_FIFO = 8'h02;
   localparam logic [7:0] IDX_STAT = 8'h03;
   localparam logic [7:0] IDX_WIN_END = 8'h04;
   localparam logic [7:0] IDX_DTYPE = 8'h20;
   localparam logic [7:0] IDX_DIR = 8'h40;
   localparam logic [7:0] IDX_MON = 8'h60;
   localparam logic [7:0] IDX_CHG = 8'h70;
   localparam logic [7:0] IDX_ERR = 8'h80;
   // ----------------------------------------
   // control registers, word index
   // ----------------------------------------
   localparam logic [9:0] CSR_IRQ_STAT = 10'h100;
   localparam logic [9:0] CSR_IRQ_MASK = 10'h101;
   localparam logic [9:0] CSR_CFG = 10'h102;
   localparam int CMD_WR_BIT = 15;
   localparam int IRQ_CHG_BIT = 0;
   localparam int IRQ_ERR_BIT = 1;
   localparam int IRQ_END_BIT = 2;
   localparam logic [2:0] IRQ_MASK_RST = 3'h0;
   localparam logic CFG_FULL_RST = 1'b1;
   // type code is arbitrary, not a real part's value
   localparam logic [7:0] PULSE_DEV_TYPE = 8'h5a;
   // bit set means the port is an output
   localparam logic [3:0] PULSE_DEV_DIR = 4'h8;
   localparam int NUM_DEV = 64;
   localparam int FIFO_WORDS = 128;
   localparam int FAULT_REPEAT = 3;

   typedef struct packed {
      logic valid;
      logic [5:0] dev;
      logic [3:0] chg;
      logic [3:0] fault;
   } smh_cyc_t;

   typedef enum {RG_WIN, RG_DTYPE, RG_DIR, RG_MON, RG_CHG, RG_ERR, RG_NONE} smh_region_t;

   function automatic smh_region_t smh_region(input logic [7:0] idx);
      if (idx < IDX_WIN_END) begin
         return RG_WIN;
      end else if (idx >= IDX_DTYPE && idx < IDX_DIR) begin
         return RG_DTYPE;
      end else if (idx >= IDX_DIR && idx < IDX_DIR + 8'h10) begin
         return RG_DIR;
      end else if (idx >= IDX_MON && idx < IDX_CHG) begin
         return RG_MON;
      end else if (idx >= IDX_CHG && idx < IDX_ERR) begin
         return RG_CHG;
      end else if (idx >= IDX_ERR && idx < IDX_ERR + 8'h10) begin
         return RG_ERR;
      end
      return RG_NONE;
   endfunction : smh_region
endpackage : smh_pkg

// *** tb/smh_link_model.sv ***
module smh_link_model import smh_pkg::*; (
   input wire logic i_clock,
   input wire logic i_rx_ready,
   input wire logic i_tx_valid,
   input wire logic [15:0] i_tx_data,
   output smh_cyc_t o_cyc,
   output logic o_comm_end,
   output logic o_comm_err,
   output logic o_tx_ready,
   output logic [15:0] o_rx_data,
   output logic o_rx_valid
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------
   // serial side stand-in
   // ----------
   // tx drains only through pop_tx, so host pushes stay visible to host pops
   initial begin
      o_cyc = '0;
      o_comm_end = 1'b0;
      o_comm_err = 1'b0;
      o_tx_ready = 1'b0;
      o_rx_data = 16'h0;
      o_rx_valid = 1'b0;
   end

   // one report per call; released fields show inverted junk
   task automatic cyc(input logic [5:0] dev, input logic [3:0] chg, input logic [3:0] flt);
      @(posedge i_clock);
      o_cyc <= '{valid: 1'b1, dev: dev, chg: chg, fault: flt};
      @(posedge i_clock);
      o_cyc <= '{valid: 1'b0, dev: ~dev, chg: ~chg, fault: ~flt};
   endtask : cyc

   task automatic end_comm(input logic err);
      @(posedge i_clock);
      o_comm_end <= 1'b1;
      o_comm_err <= err;
      @(posedge i_clock);
      o_comm_end <= 1'b0;
      o_comm_err <= ~err;
   endtask : end_comm

   // held until accepted, host traffic may stall it
   task automatic push_rx(input logic [15:0] d);
      @(posedge i_clock);
      o_rx_valid <= 1'b1;
      o_rx_data <= d;
      do @(posedge i_clock); while (i_rx_ready !== 1'b1);
      o_rx_valid <= 1'b0;
      o_rx_data <= ~d;
   endtask : push_rx

   // one word taken at the edge where valid is seen
   task automatic pop_tx(output logic [15:0] d);
      @(posedge i_clock);
      o_tx_ready <= 1'b1;
      do @(posedge i_clock); while (i_tx_valid !== 1'b1);
      d = i_tx_data;
      o_tx_ready <= 1'b0;
   endtask : pop_tx
endmodule : smh_link_model

// *** tb/testbench.sv ***
module testbench import smh_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hready, hresp, comm_end_flag, cerr, txr, txv, rxv, rxr, int_n;
   logic [31:0] hrdata;
   logic [15:0] txd, rxd;
   smh_cyc_t cyc;
   int num_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [15:0] mdl [int];

   always #2 i_clock = ~i_clock;

   smh_host_map smh_host_map_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_hsel(1'b1),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
      .i_hready(hready), .i_hwdata(hwdata), .o_hreadyout(hready), .o_hresp(hresp),
      .o_hrdata(hrdata), .i_cyc(cyc), .i_comm_end(comm_end_flag), .i_comm_err(cerr),
      .o_tx_data(txd), .o_tx_valid(txv), .i_tx_ready(txr), .i_rx_data(rxd),
      .i_rx_valid(rxv), .o_rx_ready(rxr), .o_int_n(int_n));
   smh_link_model smh_link_model_i (.i_clock(i_clock), .i_rx_ready(rxr), .o_cyc(cyc),
      .i_tx_valid(txv), .i_tx_data(txd),
      .o_comm_end(comm_end_flag), .o_comm_err(cerr), .o_tx_ready(txr), .o_rx_data(rxd),
      .o_rx_valid(rxv));

   // ----------
   // checks and bus cycles
   // ----------
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : final_report

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // waits are open here, the cycle ceiling cuts a hang
   task automatic ahb(input logic wr, input logic [9:0] idx, input logic [15:0] wd,
         output logic [31:0] rd);
      @(posedge i_clock);
      htrans <= 2'h2;
      haddr <= {20'h0, idx, 2'h0};
      hwrite <= wr;
      do @(posedge i_clock); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {16'h0, wd};
      do @(posedge i_clock); while (hready !== 1'b1);
      rd = hrdata;
      #1;
   endtask : ahb

   task automatic wr(input logic [9:0] idx, input logic [15:0] d);
      logic [31:0] rd;
      ahb(1'b1, idx, d, rd);
      mdl[idx] = d;
   endtask : wr

   task automatic w1c(input logic [9:0] idx, input logic [15:0] d);
      logic [31:0] rd;
      ahb(1'b1, idx, d, rd);
      mdl[idx] = mdl.exists(idx) ? mdl[idx] & ~d : 16'h0;
   endtask : w1c

   task automatic rdc(input logic [9:0] idx, input string nm);
      logic [31:0] rd;
      ahb(1'b0, idx, 16'h0, rd);
      chk(nm, {16'h0, mdl.exists(idx) ? mdl[idx] : 16'h0}, rd);
   endtask : rdc

   always @(posedge i_clock) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         num_errors++;
         final_report();
      end
   end

   // ----------
   // scenarios
   // ----------
   initial begin
      logic [31:0] rd;
      int d;
      logic [3:0] f;
      logic [15:0] v;
      void'($urandom(32'h03c6d270));
      repeat (12) @(posedge i_clock);
      i_rst_n <= 1'b1;
      mdl[CSR_CFG] = 16'h1;
      rdc(CSR_IRQ_MASK, "mask");
      rdc(CSR_CFG, "cfg");
      wr(IDX_DTYPE + 8'h5, {PULSE_DEV_TYPE, 8'h21});
      rdc(IDX_DTYPE + 8'h5, "type");
      wr(IDX_DIR + 8'h2, 16'h0);
      mdl[IDX_DIR + 8'h2] = {PULSE_DEV_DIR, 12'h0};
      rdc(IDX_DIR + 8'h2, "dir");
      wr(10'h90, 16'hffff);
      mdl[10'h90] = 16'h0;
      rdc(10'h90, "unmapped");
      v = 16'($urandom);
      wr(IDX_MON + 8'h1, v & 16'h0ff0);
      ahb(1'b0, IDX_MON + 8'h1, 16'h0, rd);
      wr(IDX_MON + 8'h1, (rd[15:0] & 16'h0ff0) | 16'h6001);
      rdc(IDX_MON + 8'h1, "monitor");
      smh_link_model_i.cyc(6'd7, 4'hf, 4'h0);
      smh_link_model_i.cyc(6'd4, 4'he, 4'h0);
      mdl[IDX_CHG + 8'h1] = 16'h6000;
      mdl[CSR_IRQ_STAT] = 16'h1;
      rdc(IDX_CHG + 8'h1, "change");
      rdc(CSR_IRQ_STAT, "irq");
      chk("int_n", 32'h1, {31'h0, int_n});
      wr(CSR_IRQ_MASK, 16'h3);
      chk("int_n", 32'h0, {31'h0, int_n});
      w1c(IDX_CHG + 8'h1, 16'h6000);
      w1c(CSR_IRQ_STAT, 16'h1);
      chk("int_n", 32'h1, {31'h0, int_n});
      d = $urandom_range(63);
      f = 4'($urandom_range(15, 1));
      repeat (2) smh_link_model_i.cyc(6'(d), 4'h0, f);
      rdc(10'(IDX_ERR + d / 4), "error early");
      smh_link_model_i.cyc(6'(d), 4'h0, f);
      mdl[10'(IDX_ERR + d / 4)] = 16'(f) << (4 * (d % 4));
      mdl[CSR_IRQ_STAT] = 16'h2;
      for (int i = 0; i < 16; i++) begin
         rdc(10'(IDX_ERR + i), "error");
      end
      rdc(CSR_IRQ_STAT, "irq error");
      chk("int_n", 32'h0, {31'h0, int_n});
      w1c(10'(IDX_ERR + d / 4), 16'hffff);
      rdc(10'(IDX_ERR + d / 4), "error clear");
      w1c(CSR_IRQ_STAT, 16'h2);
      for (int e = 0; e < 2; e++) begin
         smh_link_model_i.end_comm(e[0]);
         mdl[IDX_STAT] = 16'h6 | 16'(e);
         rdc(IDX_STAT, "status");
         mdl[IDX_STAT] = 16'h4;
         rdc(IDX_STAT, "status clear");
      end
      w1c(CSR_IRQ_STAT, 16'h4);
      v = 16'($urandom);
      smh_link_model_i.push_rx(v);
      mdl[IDX_FIFO] = v;
      rdc(IDX_FIFO, "fifo");
      for (int i = 0; i <= FIFO_WORDS; i++) begin
         wr(IDX_FIFO, 16'(i + 1));
      end
      mdl[IDX_STAT] = {8'(FIFO_WORDS), 8'h08};
      rdc(IDX_STAT, "fifo full");
      chk("rx_ready", 32'h0, {31'h0, rxr});
      chk("tx_valid", 32'h1, {31'h0, txv});
      chk("hresp", 32'h0, {31'h0, hresp});
      smh_link_model_i.pop_tx(rd[15:0]);
      chk("tx_data", 32'h1, {16'h0, rd[15:0]});
      mdl[IDX_STAT] = {8'(FIFO_WORDS - 1), 8'h00};
      rdc(IDX_STAT, "fifo drain");
      wr(CSR_CFG, 16'h0);
      ahb(1'b0, IDX_MON + 8'h1, 16'h0, rd);
      chk("hidden", 32'h0, rd);
      wr(IDX_CMD, {7'h0, IDX_MON + 8'h1, 1'b0});
      mdl[IDX_DATA] = mdl[IDX_MON + 8'h1];
      rdc(IDX_DATA, "indirect read");
      wr(IDX_DATA, v | 16'hf000);
      wr(IDX_CMD, {1'b1, 6'h0, IDX_MON + 8'h2, 1'b0});
      wr(IDX_CMD, {7'h0, IDX_MON + 8'h2, 1'b0});
      mdl[IDX_DATA] = v | 16'hf000;
      rdc(IDX_DATA, "indirect write");
      smh_link_model_i.cyc(6'd11, 4'hf, 4'h0);
      wr(IDX_CMD, {7'h0, IDX_CHG + 8'h2, 1'b0});
      mdl[IDX_DATA] = {4'(~PULSE_DEV_DIR), 12'h0};
      rdc(IDX_DATA, "pulse change");
      chk("int_n", 32'h0, {31'h0, int_n});
      final_report();
   end
endmodule : testbench
